// >>> dpm_map.svh
`ifndef DPM_MAP_SVH
`define DPM_MAP_SVH
// Device clock rate and the length of one interval.
`define DPM_CLK_HZ 40000000
`define DPM_SEC_S 1
`define DPM_SEC_CYC (`DPM_SEC_S * `DPM_CLK_HZ)
// Line and frame defect thresholds, severe second and unavailability limits.
`define DPM_EXZ_ZEROS 3
`define DPM_SEF_ERRS 3
`define DPM_SES_ERRS 45
`define DPM_UNAV_RUN 10
// Frames of AIC ones needed to call the signal C-bit parity.
`define DPM_AIC_RUN 8
// Alternating payload bits needed to call the signal AIS.
`define DPM_AIS_RUN 64
// Longest zero run let out of the test pattern generator.
`define DPM_QRSS_MAXZ 14
`define DPM_QRSS_SEED 20'h00001
`define DPM_FEBE_OK 3'h7
`endif

// >>> dpm_pkg.sv
`default_nettype none
package dpm_pkg;
  // Path availability, one-hot.
  typedef enum logic [1:0] {
    DPM_AVAIL   = 2'b01,
    DPM_UNAVAIL = 2'b10
  } dpm_avail_e;
endpackage
`default_nettype wire

// >>> dpm_core.sv
`timescale 1ns/100ps
`default_nettype none
`include "dpm_map.svh"
module dpm_core #(
  parameter int CNT_W   = 16,
  parameter int SEC_CYC = `DPM_SEC_CYC,
  parameter int AIC_RUN = `DPM_AIC_RUN,
  parameter int AIS_RUN = `DPM_AIS_RUN
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             bit_en_i,
  input  wire logic             pos_pulse_i,
  input  wire logic             neg_pulse_i,
  input  wire logic             subst_i,
  input  wire logic             sig_valid_i,
  input  wire logic             frame_lock_i,
  input  wire logic             fbit_en_i,
  input  wire logic             fbit_err_i,
  input  wire logic             aic_en_i,
  input  wire logic             aic_bit_i,
  input  wire logic             pay_en_i,
  input  wire logic             pay_bit_i,
  input  wire logic             pbit_err_i,
  input  wire logic             cpbit_err_i,
  input  wire logic             febe_en_i,
  input  wire logic [2:0]       febe_bits_i,
  input  wire logic             qrss_en_i,
  output logic                  los_o,
  output logic                  oof_o,
  output logic                  sef_o,
  output logic                  ais_o,
  output logic                  cbit_fmt_o,
  output logic                  bpv_o,
  output logic                  excess_zeros_event_o,
  output logic                  febe_o,
  output logic                  sec_tick_o,
  output logic                  xbit_o,
  output logic                  path_unavail_o,
  output logic                  qrss_o,
  output logic [CNT_W-1:0]      line_code_violation_count,
  output logic [CNT_W-1:0]      path_parity_violation_count,
  output logic [CNT_W-1:0]      line_errored_seconds,
  output logic [CNT_W-1:0]      path_errored_seconds,
  output logic [CNT_W-1:0]      line_los_seconds,
  output logic [CNT_W-1:0]      path_frame_alarm_seconds,
  output logic [CNT_W-1:0]      path_severe_frame_seconds,
  output logic [CNT_W-1:0]      line_severely_errored_seconds,
  output logic [CNT_W-1:0]      path_severely_errored_seconds,
  output logic [CNT_W-1:0]      path_unavailable_seconds
);
  localparam int SW   = $clog2(SEC_CYC);
  localparam int AICW = $clog2(AIC_RUN + 1);
  localparam int AISW = $clog2(AIS_RUN + 1);

  typedef struct packed {
    logic [CNT_W-1:0]   lcv;
    logic [CNT_W-1:0]   ppv;
    logic [CNT_W-1:0]   les;
    logic [CNT_W-1:0]   pes;
    logic [CNT_W-1:0]   llos;
    logic [CNT_W-1:0]   pfas;
    logic [CNT_W-1:0]   psfs;
    logic [CNT_W-1:0]   lses;
    logic [CNT_W-1:0]   pses;
    logic [CNT_W-1:0]   puas;
    logic [SW-1:0]      sec;
    logic [1:0]         zrun;
    logic               pol;
    logic               polv;
    logic [5:0]         lerr;
    logic [5:0]         perr;
    logic               slos;
    logic               ssef;
    logic               sais;
    logic [15:0]        fwin;
    logic               los;
    logic               oof;
    logic               sef;
    logic [AICW-1:0]    aicr;
    logic               cbit;
    logic [AISW-1:0]    aisr;
    logic               ais;
    logic               lpay;
    dpm_pkg::dpm_avail_e st;
    logic [3:0]         run;
    logic [19:0]        lfsr;
    logic [3:0]         qz;
    logic               qrss;
    logic               xbit;
    logic               bpv;
    logic               excess_zeros_event;
    logic               febe;
    logic               tick;
  } dpm_state_s;

  dpm_state_s r_reg;
  dpm_state_s r_next;

  logic       pulse;
  logic       tick;
  logic       los_any;
  logic       sef_any;
  logic       ais_any;
  logic       l_err;
  logic       p_err;
  logic       l_ses;
  logic       p_ses;
  logic [5:0] l6;
  logic [5:0] p6;
  logic [1:0] pinc;

  // Counters stick at all ones rather than wrap, so a full count is honest.
  function automatic logic [CNT_W-1:0] sat_add(
    input logic [CNT_W-1:0] v,
    input logic [1:0]       d);
    logic [CNT_W:0] s;
    s = {1'b0, v} + {{(CNT_W-1){1'b0}}, d};
    sat_add = s[CNT_W] ? {CNT_W{1'b1}} : s[CNT_W-1:0];
  endfunction

  // Interval error tallies only need to reach the severe threshold.
  function automatic logic [5:0] sat6(
    input logic [5:0] v,
    input logic [1:0] d);
    logic [6:0] s;
    s = {1'b0, v} + {5'h00, d};
    sat6 = s[6] ? 6'h3f : s[5:0];
  endfunction

  // All next-state logic of the monitor.
  always_comb begin
    r_next = r_reg;
    pulse = pos_pulse_i | neg_pulse_i;
    r_next.bpv = 1'b0;
    r_next.excess_zeros_event = 1'b0;
    // Line coding: polarity memory and zero run.
    if (bit_en_i) begin
      if (pulse) begin
        r_next.bpv = r_reg.polv && (r_reg.pol == pos_pulse_i) &&
                     !subst_i;
        r_next.pol = pos_pulse_i;
        r_next.polv = 1'b1;
        r_next.zrun = 2'h0;
      end else begin
        if (r_reg.zrun == 2'(`DPM_EXZ_ZEROS - 1)) begin
          r_next.excess_zeros_event = 1'b1;
        end
        if (r_reg.zrun != 2'h3) begin
          r_next.zrun = r_reg.zrun + 2'h1;
        end
      end
    end
    r_next.los = !sig_valid_i;
    r_next.oof = !frame_lock_i;
    // Sliding window over the last 16 F-bits.
    if (fbit_en_i) begin
      r_next.fwin = {r_reg.fwin[14:0], fbit_err_i};
      if ($countones(r_next.fwin) >= `DPM_SEF_ERRS) begin
        r_next.sef = 1'b1;
      end else if (frame_lock_i) begin
        r_next.sef = 1'b0;
      end
    end
    // One zero in the AIC drops back to M13 at once.
    if (aic_en_i) begin
      if (!aic_bit_i) begin
        r_next.aicr = '0;
      end else if (r_reg.aicr != AICW'(AIC_RUN)) begin
        r_next.aicr = r_reg.aicr + 1'b1;
      end
    end
    r_next.cbit = (r_next.aicr == AICW'(AIC_RUN));
    // AIS needs a framed, alternating payload for a full run.
    if (pay_en_i) begin
      if (frame_lock_i && (pay_bit_i != r_reg.lpay)) begin
        if (r_reg.aisr != AISW'(AIS_RUN)) begin
          r_next.aisr = r_reg.aisr + 1'b1;
        end
      end else begin
        r_next.aisr = '0;
      end
      r_next.lpay = pay_bit_i;
    end
    // A lost frame breaks the run, so AIS cannot come back on relock alone.
    if (!frame_lock_i) begin
      r_next.aisr = '0;
    end
    r_next.ais = frame_lock_i &&
                 (r_next.aisr == AISW'(AIS_RUN));
    r_next.febe = febe_en_i && r_reg.cbit &&
                  (febe_bits_i != `DPM_FEBE_OK);
    r_next.xbit = !(r_next.sef || r_next.ais);
    // Accumulated counts.
    pinc = {1'b0, pbit_err_i} +
           {1'b0, r_reg.cbit & cpbit_err_i};
    r_next.ppv = sat_add(r_reg.ppv, pinc);
    r_next.lcv = sat_add(r_reg.lcv,
                         {1'b0, r_next.bpv | r_next.excess_zeros_event});
    // Interval tallies include this cycle's events.
    l6 = sat6(r_reg.lerr, {1'b0, r_next.bpv | r_next.excess_zeros_event});
    p6 = sat6(r_reg.perr, pinc);
    los_any = r_reg.slos | r_next.los;
    sef_any = r_reg.ssef | r_next.sef;
    ais_any = r_reg.sais | r_next.ais;
    l_err = (l6 != 6'h00) | los_any;
    p_err = (p6 != 6'h00) | sef_any | ais_any;
    l_ses = (l6 >= 6'(`DPM_SES_ERRS)) | los_any;
    p_ses = (p6 >= 6'(`DPM_SES_ERRS)) | sef_any | ais_any;
    tick = (r_reg.sec == SW'(SEC_CYC - 1));
    r_next.tick = tick;
    r_next.sec = tick ? '0 : r_reg.sec + 1'b1;
    r_next.lerr = l6;
    r_next.perr = p6;
    r_next.slos = los_any;
    r_next.ssef = sef_any;
    r_next.sais = ais_any;
    // Second boundary: score the interval, then clear its flags.
    if (tick) begin
      r_next.les = sat_add(r_reg.les, {1'b0, l_err});
      r_next.pes = sat_add(r_reg.pes, {1'b0, p_err});
      r_next.llos = sat_add(r_reg.llos, {1'b0, los_any});
      r_next.pfas = sat_add(r_reg.pfas,
                            {1'b0, sef_any | ais_any});
      r_next.psfs = sat_add(r_reg.psfs, {1'b0, sef_any});
      r_next.lses = sat_add(r_reg.lses, {1'b0, l_ses});
      r_next.pses = sat_add(r_reg.pses, {1'b0, p_ses});
      case (r_reg.st)
        dpm_pkg::DPM_AVAIL: begin
          if (!p_ses) begin
            r_next.run = 4'h0;
          end else if (r_reg.run == 4'(`DPM_UNAV_RUN - 1)) begin
            r_next.run = 4'h0;
            r_next.st = dpm_pkg::DPM_UNAVAIL;
          end else begin
            r_next.run = r_reg.run + 4'h1;
          end
        end
        dpm_pkg::DPM_UNAVAIL: begin
          if (p_ses) begin
            r_next.run = 4'h0;
          end else if (r_reg.run == 4'(`DPM_UNAV_RUN - 1)) begin
            r_next.run = 4'h0;
            r_next.st = dpm_pkg::DPM_AVAIL;
          end else begin
            r_next.run = r_reg.run + 4'h1;
          end
        end
        default: begin
          r_next.run = 4'h0;
          r_next.st = dpm_pkg::DPM_AVAIL;
        end
      endcase
      r_next.puas = sat_add(r_reg.puas,
        {1'b0, r_next.st == dpm_pkg::DPM_UNAVAIL});
      r_next.lerr = 6'h00;
      r_next.perr = 6'h00;
      r_next.slos = 1'b0;
      r_next.ssef = 1'b0;
      r_next.sais = 1'b0;
    end
    // Test pattern: the cap forces a one without disturbing the LFSR.
    if (qrss_en_i) begin
      r_next.lfsr = {r_reg.lfsr[18:0],
                     r_reg.lfsr[19] ^ r_reg.lfsr[16]};
      if (r_reg.lfsr[19]) begin
        r_next.qrss = 1'b1;
        r_next.qz = 4'h0;
      end else if (r_reg.qz == 4'(`DPM_QRSS_MAXZ)) begin
        r_next.qrss = 1'b1;
        r_next.qz = 4'h0;
      end else begin
        r_next.qrss = 1'b0;
        r_next.qz = r_reg.qz + 4'h1;
      end
    end
  end

  // State register; X-bits idle high so no false RAI leaves at reset.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_reg <= '0;
      r_reg.lfsr <= `DPM_QRSS_SEED;
      r_reg.xbit <= 1'b1;
      r_reg.st <= dpm_pkg::DPM_AVAIL;
    end else begin
      r_reg <= r_next;
    end
  end

  // Outputs straight from the state register.
  assign los_o = r_reg.los;
  assign oof_o = r_reg.oof;
  assign sef_o = r_reg.sef;
  assign ais_o = r_reg.ais;
  assign cbit_fmt_o = r_reg.cbit;
  assign bpv_o = r_reg.bpv;
  assign excess_zeros_event_o = r_reg.excess_zeros_event;
  assign febe_o = r_reg.febe;
  assign sec_tick_o = r_reg.tick;
  assign xbit_o = r_reg.xbit;
  assign path_unavail_o = (r_reg.st == dpm_pkg::DPM_UNAVAIL);
  assign qrss_o = r_reg.qrss;
  assign line_code_violation_count = r_reg.lcv;
  assign path_parity_violation_count = r_reg.ppv;
  assign line_errored_seconds = r_reg.les;
  assign path_errored_seconds = r_reg.pes;
  assign line_los_seconds = r_reg.llos;
  assign path_frame_alarm_seconds = r_reg.pfas;
  assign path_severe_frame_seconds = r_reg.psfs;
  assign line_severely_errored_seconds = r_reg.lses;
  assign path_severely_errored_seconds = r_reg.pses;
  assign path_unavailable_seconds = r_reg.puas;

  // Checks on the monitor's own behaviour.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_defect_ends;
    (sef_o || ais_o) ##1 !(sef_o || ais_o);
  endsequence

  a_bpv_same_pol: assert property (
    bit_en_i && pos_pulse_i && !neg_pulse_i && r_reg.polv &&
    r_reg.pol && !subst_i |=> bpv_o && !excess_zeros_event_o)
    else $error("Repeated polarity pulse not flagged.");
  a_exz_third_zero: assert property (
    bit_en_i && !pulse && r_reg.zrun == 2'h2 |=>
    excess_zeros_event_o && !bpv_o)
    else $error("Third zero not flagged.");
  a_sef_raise: assert property (
    fbit_en_i && $countones({r_reg.fwin[14:0], fbit_err_i}) >= 3
    |=> sef_o && !xbit_o)
    else $error("SEF not raised on three F-bit errors.");
  a_sef_hold_oof: assert property (
    sef_o && !frame_lock_i |=> sef_o)
    else $error("SEF ended while out of frame.");
  a_rai_clear: assert property (
    s_defect_ends |-> xbit_o && $past(!xbit_o))
    else $error("X-bits not returned high.");
  a_febe_cbit: assert property (
    febe_o |-> $past(cbit_fmt_o) && $past(febe_bits_i) != 3'h7)
    else $error("FEBE outside C-bit or on all ones.");
  a_ppv_m13: assert property (
    !cbit_fmt_o && !pbit_err_i |=>
    path_parity_violation_count == $past(r_reg.ppv))
    else $error("CP-bit error counted in M13.");
  a_les_step: assert property (
    tick && los_any && r_reg.les != '1 |=>
    line_errored_seconds == $past(r_reg.les) + 1'b1 &&
    line_los_seconds != $past(r_reg.llos))
    else $error("Line errored second missed.");
  a_unav_enter: assert property (
    tick && !path_unavail_o && p_ses && r_reg.run == 4'h9 |=>
    path_unavail_o)
    else $error("Path not unavailable after ten SES.");
  a_tick_spacing: assert property (
    sec_tick_o |=> !sec_tick_o [*8])
    else $error("Second strobe repeated too soon.");
endmodule
`default_nettype wire

// >>> dpm_rx_model.sv
`timescale 1ns/100ps
`default_nettype none
// Stand-in for the line receiver and framer. It never sends positive and
// negative pulses in the same bit, and its strobes last one cycle.
module dpm_rx_model (
  input  wire logic       clk_i,
  output logic            bit_en_o,
  output logic            pos_o,
  output logic            neg_o,
  output logic            subst_o,
  output logic            fbit_en_o,
  output logic            fbit_err_o,
  output logic            aic_en_o,
  output logic            aic_o,
  output logic            pay_en_o,
  output logic            pay_o,
  output logic            perr_o,
  output logic            cperr_o,
  output logic            febe_en_o,
  output logic [2:0]      febe_o
);
  // All strobes start low so nothing is taken during reset.
  initial begin
    {bit_en_o, pos_o, neg_o, subst_o, fbit_en_o, fbit_err_o} = 6'h00;
    {aic_en_o, aic_o, pay_en_o, pay_o, perr_o, cperr_o} = 6'h00;
    {febe_en_o, febe_o} = 4'h0;
  end

  // One strobe of kind k carrying d, launched at a falling edge.
  // Pulse lines are cleared and the other data lines inverted afterwards so stale values never look valid.
  task automatic send(input logic [2:0] k, input logic [2:0] d);
    @(negedge clk_i);
    case (k)
      3'h0: {bit_en_o, pos_o, neg_o, subst_o} <= {1'b1, d[2], d[1] & ~d[2], d[0]};
      3'h1: {fbit_en_o, fbit_err_o} <= {1'b1, d[0]};
      3'h2: {aic_en_o, aic_o} <= {1'b1, d[0]};
      3'h3: {pay_en_o, pay_o} <= {1'b1, d[0]};
      3'h4: {perr_o, cperr_o} <= d[1:0];
      default: {febe_en_o, febe_o} <= {1'b1, d};
    endcase
    @(negedge clk_i);
    {bit_en_o, fbit_en_o, aic_en_o, pay_en_o, perr_o, cperr_o} <= 6'h00;
    {febe_en_o, pos_o, neg_o, subst_o} <= 4'h0;
    {aic_o, pay_o, fbit_err_o, febe_o} <= ~{aic_o, pay_o, fbit_err_o, febe_o};
  endtask
endmodule
`default_nettype wire

// >>> dpm_core_test.sv
`timescale 1ns/100ps
`include "dpm_map.svh"
`default_nettype none
module dpm_core_test;
  localparam int SEC = 200;
  localparam int W   = 16;
  localparam logic [2:0] LS [10] = '{3'b100, 3'b100, 3'b101, 3'b000, 3'b000,
                                     3'b010, 3'b000, 3'b000, 3'b000, 3'b000};
  logic         clk_i = 1'b0;
  logic         rst_i = 1'b1;
  logic         valid = 1'b1;
  logic         lock = 1'b1;
  logic         qen = 1'b0;
  wire logic    ben, pos, neg, sub, fen, ferr, aen, aic, pen, pay, pe, cpe, fben;
  wire logic [2:0] fb;
  logic         los, oof, sef, ais, cfmt, bpv, excess_zeros_event, febe, tk, xbit, unav, qrss;
  logic [W-1:0] cnt [10];
  int           errors = 0;
  int           samples_checked = 0;
  int           seed = 62911;
  int           nb = 0, nz = 0, nf = 0, cyc = 0, last = -1;
  int           i, run, maxr, ones;
  int           rq = 0, ref1 = 0;
  logic [19:0]  rl = `DPM_QRSS_SEED;
  logic         eb;

  // Clock at 40 MHz.
  always #12.5 clk_i = ~clk_i;

  dpm_rx_model dpm_rx_model_i (.clk_i(clk_i), .bit_en_o(ben), .pos_o(pos),
    .neg_o(neg), .subst_o(sub), .fbit_en_o(fen), .fbit_err_o(ferr),
    .aic_en_o(aen), .aic_o(aic), .pay_en_o(pen), .pay_o(pay), .perr_o(pe),
    .cperr_o(cpe), .febe_en_o(fben), .febe_o(fb));

  dpm_core #(.CNT_W(W), .SEC_CYC(SEC)) dpm_core_i (.clk_i(clk_i), .rst_i(rst_i),
    .bit_en_i(ben), .pos_pulse_i(pos), .neg_pulse_i(neg), .subst_i(sub),
    .sig_valid_i(valid), .frame_lock_i(lock), .fbit_en_i(fen),
    .fbit_err_i(ferr), .aic_en_i(aen), .aic_bit_i(aic), .pay_en_i(pen),
    .pay_bit_i(pay), .pbit_err_i(pe), .cpbit_err_i(cpe), .febe_en_i(fben),
    .febe_bits_i(fb), .qrss_en_i(qen), .los_o(los), .oof_o(oof), .sef_o(sef),
    .ais_o(ais), .cbit_fmt_o(cfmt), .bpv_o(bpv), .excess_zeros_event_o(excess_zeros_event),
    .febe_o(febe), .sec_tick_o(tk), .xbit_o(xbit), .path_unavail_o(unav),
    .qrss_o(qrss), .line_code_violation_count(cnt[0]),
    .path_parity_violation_count(cnt[1]), .line_errored_seconds(cnt[2]),
    .path_errored_seconds(cnt[3]), .line_los_seconds(cnt[4]),
    .path_frame_alarm_seconds(cnt[5]), .path_severe_frame_seconds(cnt[6]),
    .line_severely_errored_seconds(cnt[7]),
    .path_severely_errored_seconds(cnt[8]), .path_unavailable_seconds(cnt[9]));

  // Pulses are tallied at the rising edge, where the registered values
  // are still the settled ones; a hang is cut off well past the plan.
  always @(posedge clk_i) begin
    nb += bpv;
    nz += excess_zeros_event;
    nf += febe;
    cyc++;
    if (cyc == 12000) begin
      errors++;
      final_report();
    end
  end

  task automatic check(input string what, input logic [W-1:0] seen,
                       input logic [W-1:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Waits for the interval strobe and checks its spacing.
  task automatic tick();
    do @(negedge clk_i); while (tk !== 1'b1);
    if (last >= 0) check("tick gap", W'(cyc - last), W'(SEC));
    last = cyc;
  endtask

  task automatic settle();
    repeat (3) @(negedge clk_i);
  endtask

  initial begin
    repeat (20) @(negedge clk_i);
    rst_i = 1'b0;
    @(negedge clk_i);
    check("xbit", xbit, 1);
    for (i = 0; i < 10; i++) check("count", cnt[i], 0);
    // The test pattern must toggle and never run too long at zero.
    run = 0;
    maxr = 0;
    ones = 0;
    repeat (300) begin
      @(negedge clk_i);
      qen = 1'b1;
      @(negedge clk_i);
      qen = 1'b0;
      // Reference pattern: x^20+x^17+1, a one forced after the zero cap.
      eb = rl[19] || (rq == `DPM_QRSS_MAXZ);
      rq = eb ? 0 : rq + 1;
      rl = {rl[18:0], rl[19] ^ rl[16]};
      ref1 += eb;
      check("qrss bit", qrss, eb);
      run = (qrss === 1'b1) ? 0 : run + 1;
      maxr = (run > maxr) ? run : maxr;
      ones += (qrss === 1'b1);
    end
    check("zero run cap", maxr <= `DPM_QRSS_MAXZ, 1);
    check("pattern mix", ones, ref1);
    tick();
    // Line errors: one real violation, one substitution pulse, two zero runs.
    for (i = 0; i < 10; i++) dpm_rx_model_i.send(3'h0, LS[i]);
    settle();
    check("bpv pulses", nb, 1);
    check("zero events", nz, 1);
    tick();
    check("line cv", cnt[0], 2);
    check("line es", cnt[2], 1);
    check("line ses", cnt[7], 0);
    // M13 traffic: random AIC, CP errors and FEBE are ignored.
    for (i = 0; i < 6; i++)
      dpm_rx_model_i.send(3'h2, (i == 3) ? 3'h0 : 3'($random(seed)));
    dpm_rx_model_i.send(3'h5, 3'h0);
    repeat (45) dpm_rx_model_i.send(3'h4, 3'h3);
    settle();
    check("m13 format", cfmt, 0);
    check("febe m13", nf, 0);
    tick();
    check("path cv", cnt[1], 45);
    check("path es", cnt[3], 1);
    check("path ses", cnt[8], 1);
    // C-bit traffic, random far-end errors, then a short signal loss.
    repeat (8) dpm_rx_model_i.send(3'h2, 3'h1);
    dpm_rx_model_i.send(3'h4, 3'h3);
    dpm_rx_model_i.send(3'h5, 3'h7);
    for (i = 0; i < 4; i++)
      dpm_rx_model_i.send(3'h5, 3'($random(seed)) & 3'h6);
    settle();
    check("cbit format", cfmt, 1);
    check("febe count", nf, 4);
    valid = 1'b0;
    lock = 1'b0;
    settle();
    check("los", los, 1);
    check("oof", oof, 1);
    valid = 1'b1;
    lock = 1'b1;
    tick();
    check("path cv", cnt[1], 47);
    check("line es", cnt[2], 2);
    check("line los s", cnt[4], 1);
    check("line ses", cnt[7], 1);
    // Alarm pattern in frame, removed by losing frame.
    for (i = 0; i < 70; i++) dpm_rx_model_i.send(3'h3, 3'(i & 1));
    settle();
    check("ais", ais, 1);
    check("xbit rai", xbit, 0);
    lock = 1'b0;
    settle();
    lock = 1'b1;
    check("ais gone", ais, 0);
    check("xbit clear", xbit, 1);
    tick();
    check("frame alarm s", cnt[5], 1);
    check("severe frame s", cnt[6], 0);
    tick();
    // Two F-bit errors are tolerated, the third raises the defect.
    for (i = 0; i < 4; i++) begin
      dpm_rx_model_i.send(3'h1, 3'(i != 1));
      settle();
      if (i == 2) check("sef early", sef, 0);
    end
    check("sef", sef, 1);
    check("xbit rai", xbit, 0);
    for (i = 1; i <= 10; i++) begin
      tick();
      if (i == 9) check("still avail", unav, 0);
    end
    check("unavailable", unav, 1);
    check("unavail s", cnt[9], 1);
    check("severe frame s", cnt[6], 10);
    check("frame alarm s", cnt[5], 11);
    repeat (16) dpm_rx_model_i.send(3'h1, 3'h0);
    settle();
    check("sef end", sef, 0);
    check("xbit clear", xbit, 1);
    for (i = 0; i <= 10; i++) begin
      tick();
      if (i == 9) check("still unavail", unav, 1);
    end
    check("available", unav, 0);
    check("unavail s", cnt[9], 11);
    check("path ses", cnt[8], 13);
    final_report();
  end
endmodule
`default_nettype wire
